// ---- gcsr_pkg.sv ----
// package with offsets, field positions and reset values for the gigabit regs
package gcsr_pkg;
  localparam logic [4:0]  ADDR_CONTROL    = 5'h09;
  localparam logic [4:0]  ADDR_STATUS     = 5'h0a;
  localparam int          TEST_MSB        = 15;
  localparam int          TEST_LSB        = 13;
  localparam int          MANUAL_BIT      = 12;
  localparam int          VALUE_BIT       = 11;
  localparam int          PORT_BIT        = 10;
  localparam int          ADV_FD_BIT      = 9;
  localparam int          ADV_HD_BIT      = 8;
  localparam int          FAULT_BIT       = 15;
  localparam int          RESOLVED_BIT    = 14;
  localparam int          LOCAL_OK_BIT    = 13;
  localparam int          REMOTE_OK_BIT   = 12;
  localparam int          LP_FD_BIT       = 11;
  localparam int          LP_HD_BIT       = 10;
  localparam logic [2:0]  TEST_RESET      = 3'h0;
  localparam logic [7:0]  IDLE_CNT_RESET  = 8'h00;
  localparam logic [7:0]  IDLE_CNT_MAX    = 8'hff;
  localparam logic [15:0] CONTROL_WMASK   = 16'hff00;
  // edges after release while the strap is reloaded: two sync flops + one
  localparam logic [1:0]  STRAP_WAIT      = 2'h3;

  typedef enum logic [2:0] {
    GCSR_TEST_NORMAL, GCSR_TEST_WAVEFORM, GCSR_TEST_MASTER_JITTER,
    GCSR_TEST_SLAVE_JITTER, GCSR_TEST_DISTORTION
  } gcsr_test_t;

  // management access request as seen by the register bank
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } gcsr_req_t;

  // gigabit abilities carried to the autonegotiation engine
  typedef struct packed {
    logic manual_en;
    logic manual_master;
    logic prefer_multiport;
    logic adv_full;
    logic adv_half;
  } gcsr_ability_t;
endpackage

// ---- gcsr_idle_counter.sv ----
// saturating idle error counter, cleared by a status read
`timescale 1ns/1ps
module gcsr_idle_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // events
  input  wire logic             count_en,
  input  wire logic             clear,
  // count
  output logic      [WIDTH-1:0] count
);
  localparam logic [WIDTH-1:0] MAXV = '1;

  logic [WIDTH-1:0] base;

  // a clear in the same cycle as an error leaves a count of one
  always_comb begin
    base = clear ? '0 : count;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (count_en && base != MAXV) begin
      count <= base + WIDTH'(1);
    end else begin
      count <= base;
    end
  end

  counter_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (count == MAXV && !clear) |=> count == MAXV)
    else $error("idle counter wrapped");
endmodule

// ---- gcsr_regs.sv ----
// gigabit control and status registers on the management interface
//
// Notes on behaviour
// - test selector picks test mode, resets normal
// - manual enable picks configured role, else automatic
// - value bit sets master/slave only when manual
// - port type prefers multiport when set
// - advertise bits reset from speed strap
// - bits 12:8 extend advertised ability field
// - fault latches until read, reset, autoneg events
// - resolution bit shows master, invalid during fault
// - local receiver ok status, resets zero
// - remote receiver ok status, resets zero
// - partner gigabit full/half ability read-only bits
// - count idle errors while both receivers ok
// - idle error count saturates at 255
// - count cleared by reset or status read
`timescale 1ns/1ps
module gcsr_regs (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // speed strap pin
  input  wire logic                   speed_strap,
  // management access
  input  wire gcsr_pkg::gcsr_req_t    req,
  output logic                        rd_valid,
  output logic [15:0]                 rd_data,
  // status from the physical layer
  input  wire logic                   ms_fault_evt,
  input  wire logic                   resolved_master,
  input  wire logic                   local_rx_ok,
  input  wire logic                   remote_rx_ok,
  input  wire logic                   lp_full,
  input  wire logic                   lp_half,
  input  wire logic                   idle_err_evt,
  input  wire logic                   an_complete,
  input  wire logic                   an_enable_evt,
  // control to the physical layer
  output logic [2:0]                  test_mode,
  output gcsr_pkg::gcsr_ability_t     ability,
  output logic                        manual_role,
  output logic                        role_master
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic       strap_s;
  logic       fault_s;
  logic       resolved_s;
  logic       local_s;
  logic       remote_s;
  logic       lpf_s;
  logic       lph_s;
  logic       idle_s;

  // pins come from the line side, so two flops before any use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= {speed_strap, ms_fault_evt, resolved_master, local_rx_ok,
                remote_rx_ok, lp_full, lp_half, idle_err_evt};
      sync2 <= sync1;
    end
  end

  always_comb begin
    {strap_s, fault_s, resolved_s, local_s, remote_s, lpf_s, lph_s,
     idle_s} = sync2;
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [15:0] control;
  logic [1:0]  strap_wait;
  logic        wr_ctl;
  logic        rd_sts;

  always_comb begin
    wr_ctl = req.wr && req.addr == gcsr_pkg::ADDR_CONTROL;
    rd_sts = req.rd && req.addr == gcsr_pkg::ADDR_STATUS;
  end

  // the sync flops sit in reset too, so the strap is reloaded until it has
  // crossed both; a host write ends the window so it is not overwritten
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_wait <= 2'h0;
    end else if (wr_ctl) begin
      strap_wait <= gcsr_pkg::STRAP_WAIT;
    end else if (strap_wait != gcsr_pkg::STRAP_WAIT) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control <= {gcsr_pkg::TEST_RESET, 13'h0000};
    end else if (wr_ctl) begin
      control <= req.wdata & gcsr_pkg::CONTROL_WMASK;
    end else if (strap_wait != gcsr_pkg::STRAP_WAIT) begin
      control[gcsr_pkg::ADV_FD_BIT] <= strap_s;
      control[gcsr_pkg::ADV_HD_BIT] <= strap_s;
    end
  end

  // outputs registered from the control bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_mode   <= gcsr_pkg::TEST_RESET;
      ability     <= '0;
      manual_role <= 1'b0;
      role_master <= 1'b0;
    end else begin
      test_mode   <= control[gcsr_pkg::TEST_MSB:gcsr_pkg::TEST_LSB];
      ability     <= control[gcsr_pkg::MANUAL_BIT:gcsr_pkg::ADV_HD_BIT];
      manual_role <= control[gcsr_pkg::MANUAL_BIT];
      // value bit only matters in manual mode
      role_master <= control[gcsr_pkg::MANUAL_BIT] ?
                     control[gcsr_pkg::VALUE_BIT] :
                     control[gcsr_pkg::PORT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic       fault;
  logic       resolved;
  logic       local_ok;
  logic       remote_ok;
  logic       lp_fd;
  logic       lp_hd;
  logic [7:0] idle_cnt;

  // set beats the clear so a fault in the read cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault <= 1'b0;
    end else if (fault_s) begin
      fault <= 1'b1;
    end else if (rd_sts || an_complete || an_enable_evt) begin
      fault <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resolved  <= 1'b0;
      local_ok  <= 1'b0;
      remote_ok <= 1'b0;
      lp_fd     <= 1'b0;
      lp_hd     <= 1'b0;
    end else begin
      resolved  <= resolved_s;
      local_ok  <= local_s;
      remote_ok <= remote_s;
      lp_fd     <= lpf_s;
      lp_hd     <= lph_s;
    end
  end

  gcsr_idle_counter #(
    .WIDTH (8)
  ) u_idle (
    .clk      (clk),
    .rst_n    (rst_n),
    .count_en (idle_s && local_ok && remote_ok),
    .clear    (rd_sts),
    .count    (idle_cnt)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [15:0] status_word;

  always_comb begin
    status_word = {fault, resolved, local_ok, remote_ok, lp_fd, lp_hd,
                   2'b00, idle_cnt};
  end

  // data is the pre-clear snapshot, taken in the read cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end else begin
      rd_valid <= req.rd;
      if (req.rd && req.addr == gcsr_pkg::ADDR_CONTROL) begin
        rd_data <= control;
      end else if (rd_sts) begin
        rd_data <= status_word;
      end else begin
        rd_data <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  fault_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault_s |=> fault)
    else $error("fault not latched");

  fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (fault && !fault_s && !rd_sts && !an_complete && !an_enable_evt)
    |=> fault)
    else $error("fault dropped early");

  read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_sts && !idle_s) |=> idle_cnt == 8'h00)
    else $error("count not cleared by read");

  read_snap_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_sts |=> rd_data[7:0] == $past(idle_cnt)
               && rd_data[15] == $past(fault))
    else $error("read not pre-clear value");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid |-> rd_data[9:8] == 2'b00 || $past(req.addr) !=
                 gcsr_pkg::ADDR_STATUS)
    else $error("reserved status bits set");

  ctl_low_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    control[7:0] == 8'h00)
    else $error("reserved control bits set");

  count_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!(local_ok && remote_ok) && !rd_sts) |=> $stable(idle_cnt))
    else $error("count moved while link bad");

  role_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 control[gcsr_pkg::MANUAL_BIT] |=>
    role_master == $past(control[gcsr_pkg::VALUE_BIT]))
    else $error("manual role not applied");

  rx_status_a: assert property (@(posedge clk) disable iff (!rst_n)
    local_s |=> local_ok)
    else $error("local status not tracked");
endmodule

// ---- gcsr_host.sv ----
// management host model issuing register reads and writes
`timescale 1ns/1ps
module gcsr_host (
  // clock
  input  wire logic            clk,
  // management access
  output gcsr_pkg::gcsr_req_t  req,
  input  wire logic            rd_valid,
  input  wire logic [15:0]     rd_data
);
  initial req = '0;

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{1'h0, 1'h1, a, d};
    @(posedge clk) req <= '0;
  endtask

  // apart from reset, a status read is the only way to restart the idle count
  task automatic rd(input logic [4:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge clk) req <= '{1'h1, 1'h0, a, 16'h0000};
    @(posedge clk) req <= '0;
    @(posedge clk) begin
      d = rd_data;
      v = rd_valid;
    end
  endtask
endmodule

// ---- gigabit_ctrl_status_regs_bench.sv ----
// self-checking bench for the gigabit control and status registers
`timescale 1ns/1ps
module gigabit_ctrl_status_regs_bench;
  typedef struct packed {
    logic [15:0] w;
    logic [15:0] r;
    logic        rm;
  } gcsr_row_t;

  logic                    clk, rst_n, speed_strap, rd_valid;
  logic                    flt, res, lok, rok, lpf, lph, err, anc, ane;
  logic                    manual_role, role_master;
  logic [15:0]             rd_data;
  logic [2:0]              test_mode;
  gcsr_pkg::gcsr_req_t     req;
  gcsr_pkg::gcsr_ability_t ability;
  int                      fail_count, compares;
  gcsr_row_t rows[10] = '{'{16'h00ff, 16'h0000, 1'h0},
    '{16'h2000, 16'h2000, 1'h0}, '{16'h4000, 16'h4000, 1'h0},
    '{16'h6000, 16'h6000, 1'h0}, '{16'h8000, 16'h8000, 1'h0},
    '{16'ha000, 16'ha000, 1'h0}, '{16'h1800, 16'h1800, 1'h1},
    '{16'h1400, 16'h1400, 1'h0}, '{16'h0800, 16'h0800, 1'h0},
    '{16'h0700, 16'h0700, 1'h1}};

  gcsr_host gcsr_host_i (.clk(clk), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data));
  gcsr_regs gcsr_regs_i (.clk(clk), .rst_n(rst_n),
    .speed_strap(speed_strap), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .ms_fault_evt(flt), .resolved_master(res),
    .local_rx_ok(lok), .remote_rx_ok(rok), .lp_full(lpf), .lp_half(lph),
    .idle_err_evt(err), .an_complete(anc), .an_enable_evt(ane),
    .test_mode(test_mode), .ability(ability),
    .manual_role(manual_role), .role_master(role_master));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(string n, logic e, logic g);
    chk_word(n, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic rd_chk(logic [4:0] a, logic [15:0] e);
    logic [15:0] d;
    logic        v;
    gcsr_host_i.rd(a, d, v);
    chk_bit("rd_valid", 1'h1, v);
    chk_word("rd_data", e, d);
  endtask

  function automatic logic [15:0] st(logic f, logic [7:0] c);
    return {f, res, lok, rok, lpf, lph, 2'h0, c};
  endfunction

  task automatic idle(int n);
    repeat (n) @(posedge clk);
  endtask

  // each held cycle is one synced error event
  task automatic errs(int n);
    @(posedge clk) err <= 1'h1;
    idle(n);
    err <= 1'h0;
    idle(5);
  endtask

  task automatic fault_clr(bit by_an);
    @(posedge clk) flt <= 1'h1;
    @(posedge clk) flt <= 1'h0;
    idle(5);
    if (by_an) anc <= 1'h1;
    else ane <= 1'h1;
    @(posedge clk) {anc, ane} <= 2'h0;
    idle(2);
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'h00));
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    idle(5000);
    fail_count++;
    finish_test;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, flt, res, lok, rok, lpf, lph, err, anc, ane} = '0;
    speed_strap = 1'h1;
    idle(10);
    chk_bit("manual_role", 1'h0, manual_role);
    rst_n <= 1'h1;
    idle(2);
    rd_chk(gcsr_pkg::ADDR_CONTROL, 16'h0300);
    rd_chk(gcsr_pkg::ADDR_STATUS, 16'h0000);
    chk_word("test_mode", 16'h0000, {13'h0000, test_mode});
    $display("test reset done");
    foreach (rows[i]) begin
      gcsr_host_i.wr(gcsr_pkg::ADDR_CONTROL, rows[i].w);
      idle(2);
      rd_chk(gcsr_pkg::ADDR_CONTROL, rows[i].r);
      chk_word("test_mode", rows[i].r & 16'he000,
               {test_mode, 13'h0000});
      chk_word("ability", rows[i].r & 16'h1f00,
               {3'h0, ability, 8'h00});
      chk_bit("manual_role", rows[i].r[12], manual_role);
      chk_bit("role_master", rows[i].rm, role_master);
    end
    $display("test control rows done");
    gcsr_host_i.wr(gcsr_pkg::ADDR_STATUS, 16'hffff);
    gcsr_host_i.wr(5'h05, 16'hffff);
    rd_chk(gcsr_pkg::ADDR_CONTROL, 16'h0700);
    rd_chk(5'h05, 16'h0000);
    {res, lok, rok, lpf} <= 4'hf;
    idle(5);
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'h00));
    errs(10);
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'h0a));
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'h00));
    {rok, lpf, lph} <= 3'h1;
    errs(7);
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'h00));
    rok <= 1'h1;
    errs(300);
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'hff));
    $display("test idle count done");
    @(posedge clk) flt <= 1'h1;
    @(posedge clk) flt <= 1'h0;
    idle(5);
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h1, 8'h00));
    rd_chk(gcsr_pkg::ADDR_STATUS, st(1'h0, 8'h00));
    fault_clr(1'h1);
    fault_clr(1'h0);
    $display("test fault done");
    speed_strap <= 1'h0;
    idle(3);
    rst_n <= 1'h0;
    idle(2);
    rst_n <= 1'h1;
    idle(2);
    rd_chk(gcsr_pkg::ADDR_CONTROL, 16'h0000);
    $display("test second reset done");
    finish_test;
  end
endmodule
